// [src/surg_pkg.sv]
// Package: register map, hold-time table, state encodings and carrier structs for the supervisor
package surg_pkg;

   // Register map on the plain port (word index)
   localparam logic [3:0] SURG_ADDR_CTRL   = 4'h0;
   localparam logic [3:0] SURG_ADDR_STATUS = 4'h1;
   localparam logic [3:0] SURG_ADDR_WRCHK  = 4'h2;
   localparam int         SURG_ADDR_W      = 4;

   // Control setting register fields
   localparam int SURG_CTRL_HOLD_LO  = 0;
   localparam int SURG_CTRL_HOLD_HI  = 1;
   localparam int SURG_CTRL_BLK_LO   = 2;
   localparam int SURG_CTRL_BLK_HI   = 3;
   localparam logic [7:0] SURG_CTRL_RESET = 8'h01;

   // Hold times selectable by the two select bits, in microseconds
   localparam int SURG_CLK_MHZ      = 100;
   localparam int SURG_HOLD_US_SEL0 = 50;
   localparam int SURG_HOLD_US_SEL1 = 200;
   localparam int SURG_HOLD_US_SEL2 = 400;
   localparam int SURG_HOLD_US_SEL3 = 800;
   localparam int SURG_HOLD_CYC_SEL0 = SURG_HOLD_US_SEL0 * SURG_CLK_MHZ;
   localparam int SURG_HOLD_CYC_SEL1 = SURG_HOLD_US_SEL1 * SURG_CLK_MHZ;
   localparam int SURG_HOLD_CYC_SEL2 = SURG_HOLD_US_SEL2 * SURG_CLK_MHZ;
   localparam int SURG_HOLD_CYC_SEL3 = SURG_HOLD_US_SEL3 * SURG_CLK_MHZ;
   localparam int SURG_CNT_W         = 20;

   // Write kinds checked by the guard
   localparam logic [1:0] SURG_WR_NONE = 2'h0;
   localparam logic [1:0] SURG_WR_VOL  = 2'h1;
   localparam logic [1:0] SURG_WR_NV   = 2'h2;

   typedef enum logic [2:0] {
      SURG_ST_ASSERT = 3'b001,
      SURG_ST_HOLD   = 3'b010,
      SURG_ST_IDLE   = 3'b100
   } surg_state_t;

   // Synchronised comparator and pin levels
   typedef struct packed {
      logic supply_low;
      logic manual_reset;
      logic write_protect;
      logic second_mon;
      logic third_mon;
   } surg_levels_t;

   typedef struct packed {
      logic [1:0] kind;
      logic       valid;
   } surg_wreq_t;

endpackage

// [src/surg_sync.sv]
// Two-flop synchroniser for a vector of asynchronous levels
module surg_sync
   import surg_pkg::*;
#(
   parameter int WIDTH = 5
) (
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] reset_val,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;
   logic             init_q;

   always_comb begin
      meta_d = async_in;
      sync_d = init_q ? meta_q : reset_val;
   end

   // Flops take constants under reset; the chosen idle levels load on the first clocked edge
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= '0;
         sync_q <= '0;
         init_q <= 1'b0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         init_q <= 1'b1;
      end
   end

   assign sync_out = sync_q;

endmodule

// [src/surg_top.sv]
// Supervisor: supply reset sequencing, monitor fail outputs, write guard and control register
//
// Summary of operation
// - Manual reset input high starts a reset cycle, raising supply reset output.
// - After manual reset falls, supply reset stays high for the hold time.
// - Two select bits in the control register choose the hold time.
// - Write-protect high refuses every nonvolatile write.
// - Write-protect high with block bits nonzero refuses all writes.
// - Undriven write-protect counts as low, protection off.
// - Second fail output high above its trip level, low below it.
// - Second fail output follows its comparator with no hold delay.
// - Supply reset asserted whenever supply comparator reports supply below trip.
// - At power-up supply reset asserts and holds for hold time after supply stabilises.
// - Serial data line is sampled always, its input never gated.
// - Third fail output follows its comparator with no delay logic.
module surg_top
   import surg_pkg::*;
#(
   parameter int HOLD_CYC_SEL0 = SURG_HOLD_CYC_SEL0,
   parameter int HOLD_CYC_SEL1 = SURG_HOLD_CYC_SEL1,
   parameter int HOLD_CYC_SEL2 = SURG_HOLD_CYC_SEL2,
   parameter int HOLD_CYC_SEL3 = SURG_HOLD_CYC_SEL3
) (
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   // Comparator results and pins, asynchronous
   input  wire logic                  supply_low_in,
   input  wire logic                  manual_reset_in,
   input  wire logic                  write_protect_in,
   input  wire logic                  write_protect_driven,
   input  wire logic                  second_monitor_in,
   input  wire logic                  third_monitor_in,
   input  wire logic                  serial_data_in,
   // Register port
   input  wire logic [SURG_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [7:0]            reg_rdata,
   // Outputs
   output logic                       supply_reset_out,
   output logic                       second_monitor_fail_out,
   output logic                       third_monitor_fail_out,
   output logic                       serial_data_sampled,
   output logic                       write_allowed,
   output logic                       write_refused
);

   function automatic logic [SURG_CNT_W-1:0] hold_cycles(input logic [1:0] sel);
      logic [SURG_CNT_W-1:0] r;
      r = SURG_CNT_W'(HOLD_CYC_SEL0);
      case (sel)
         2'h0:    r = SURG_CNT_W'(HOLD_CYC_SEL0);
         2'h1:    r = SURG_CNT_W'(HOLD_CYC_SEL1);
         2'h2:    r = SURG_CNT_W'(HOLD_CYC_SEL2);
         2'h3:    r = SURG_CNT_W'(HOLD_CYC_SEL3);
         default: r = SURG_CNT_W'(HOLD_CYC_SEL0);
      endcase
      return r;
   endfunction

   // Synchronise every pin on its own; supply_low idles high so power-up starts asserted
   localparam logic [6:0] SYNC_IDLE = 7'h40;
   logic [6:0]   sync_raw;
   surg_levels_t lv;
   logic         sda_s;

   surg_sync #(.WIDTH(7)) u_sync (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .async_in  ({supply_low_in, manual_reset_in, write_protect_in, write_protect_driven,
                   second_monitor_in, third_monitor_in, serial_data_in}),
      .reset_val (SYNC_IDLE),
      .sync_out  (sync_raw)
   );

   // Undriven write-protect resolves to the pull-down level; gated only after both bits are synchronised
   assign lv    = surg_levels_t'({sync_raw[6:5], sync_raw[4] & sync_raw[3], sync_raw[2:1]});
   assign sda_s = sync_raw[0];

   // Control setting register and write guard
   logic [7:0] ctrl_q;
   logic [7:0] ctrl_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic       allow_q;
   logic       allow_d;
   logic       refuse_q;
   logic       refuse_d;
   logic       blk_active;
   surg_wreq_t wreq;

   assign blk_active = (ctrl_q[SURG_CTRL_BLK_HI:SURG_CTRL_BLK_LO] != 2'h0);
   // Write check register: software submits a write kind, guard answers allowed or refused
   assign wreq.valid = reg_wr && (reg_addr == SURG_ADDR_WRCHK);
   assign wreq.kind  = reg_wdata[1:0];

   function automatic logic write_ok(input logic [1:0] kind, input logic wp, input logic blk);
      logic ok;
      ok = 1'b1;
      if (wp && kind == SURG_WR_NV) begin
         ok = 1'b0;
      end
      if (wp && blk && kind != SURG_WR_NONE) begin
         ok = 1'b0;
      end
      return ok;
   endfunction

   always_comb begin
      ctrl_d   = ctrl_q;
      rdata_d  = 8'h00;
      allow_d  = 1'b0;
      refuse_d = 1'b0;
      if (reg_wr && reg_addr == SURG_ADDR_CTRL) begin
         // The control register is nonvolatile, so it obeys the guard too
         if (write_ok(SURG_WR_NV, lv.write_protect, blk_active)) begin
            ctrl_d = {4'h0, reg_wdata[3:0]};
         end else begin
            refuse_d = 1'b1;
         end
      end
      if (wreq.valid && wreq.kind != SURG_WR_NONE) begin
         allow_d  = write_ok(wreq.kind, lv.write_protect, blk_active);
         refuse_d = !allow_d;
      end
      if (reg_rd) begin
         case (reg_addr)
            SURG_ADDR_CTRL:   rdata_d = ctrl_q;
            SURG_ADDR_STATUS: rdata_d = {2'h0, sda_s, lv.write_protect, lv.third_mon, lv.second_mon,
                                         lv.supply_low, supply_reset_out};
            default:          rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q   <= SURG_CTRL_RESET;
         rdata_q  <= 8'h00;
         allow_q  <= 1'b0;
         refuse_q <= 1'b0;
      end else begin
         ctrl_q   <= ctrl_d;
         rdata_q  <= rdata_d;
         allow_q  <= allow_d;
         refuse_q <= refuse_d;
      end
   end

   // Reset sequencer
   surg_state_t           st_q;
   surg_state_t           st_d;
   logic [SURG_CNT_W-1:0] cnt_q;
   logic [SURG_CNT_W-1:0] cnt_d;
   logic                  rst_q;
   logic                  rst_d;
   logic                  cause;

   assign cause = lv.supply_low | lv.manual_reset;

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      rst_d = 1'b1;
      case (st_q)
         SURG_ST_ASSERT: begin
            // Hold length latched when the cause clears; a later select change waits for the next cycle
            if (!cause) begin
               st_d  = SURG_ST_HOLD;
               cnt_d = hold_cycles(ctrl_q[SURG_CTRL_HOLD_HI:SURG_CTRL_HOLD_LO]);
            end
         end
         SURG_ST_HOLD: begin
            if (cause) begin
               st_d = SURG_ST_ASSERT;
            end else if (cnt_q <= SURG_CNT_W'(1)) begin
               st_d  = SURG_ST_IDLE;
               rst_d = 1'b0;
            end else begin
               cnt_d = cnt_q - SURG_CNT_W'(1);
            end
         end
         SURG_ST_IDLE: begin
            rst_d = 1'b0;
            if (cause) begin
               st_d  = SURG_ST_ASSERT;
               rst_d = 1'b1;
            end
         end
         default: begin
            st_d = SURG_ST_ASSERT;
         end
      endcase
   end

   // Power-up: reset asserts from the first cycle
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_q  <= SURG_ST_ASSERT;
         cnt_q <= '0;
         rst_q <= 1'b1;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         rst_q <= rst_d;
      end
   end

   // Monitor fail outputs follow their comparators, synchroniser latency plus one output register
   logic mon2_q;
   logic mon3_q;
   logic sda_q;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         mon2_q <= 1'b0;
         mon3_q <= 1'b0;
         sda_q  <= 1'b0;
      end else begin
         mon2_q <= lv.second_mon;
         mon3_q <= lv.third_mon;
         sda_q  <= sda_s;
      end
   end

   assign supply_reset_out        = rst_q;
   assign second_monitor_fail_out = mon2_q;
   assign third_monitor_fail_out  = mon3_q;
   assign serial_data_sampled     = sda_q;
   assign reg_rdata               = rdata_q;
   assign write_allowed           = allow_q;
   assign write_refused           = refuse_q;

endmodule

// [tb/surg_board.sv]
// Board model: drives the write-protect pin, which wanders while nobody drives it
module surg_board (
   input  wire logic sys_clk,
   input  wire logic wp_level,
   input  wire logic wp_drive,
   output logic      wp_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic drift_q = 1'b0;
   always @(posedge sys_clk) begin
      drift_q <= ~drift_q;
   end
   // A floating pin holds no level; only the device's own pull-down may decide it
   assign wp_pin = wp_drive ? wp_level : drift_q;
endmodule

// [tb/surg_chk_assertions.sv]
// Checker: port-level properties of the supervisor
module surg_chk
   import surg_pkg::*;
#(
   parameter int HOLD_CYC_SEL3 = SURG_HOLD_CYC_SEL3
) (
   input wire logic                   sys_clk,
   input wire logic                   resetn,
   input wire logic                   supply_low_in,
   input wire logic                   manual_reset_in,
   input wire logic                   write_protect_in,
   input wire logic                   write_protect_driven,
   input wire logic                   second_monitor_in,
   input wire logic                   third_monitor_in,
   input wire logic                   serial_data_in,
   input wire logic [SURG_ADDR_W-1:0] reg_addr,
   input wire logic [7:0]             reg_wdata,
   input wire logic                   reg_wr,
   input wire logic                   supply_reset_out,
   input wire logic                   second_monitor_fail_out,
   input wire logic                   third_monitor_fail_out,
   input wire logic                   serial_data_sampled,
   input wire logic                   write_allowed,
   input wire logic                   write_refused
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   logic [2:0] up_q;
   logic [2:0] up_d;
   int         hold_q;
   int         hold_d;
   logic       cause;
   logic       wp_on;
   logic       nv_wr;
   assign cause = supply_low_in | manual_reset_in;
   assign wp_on = write_protect_in & write_protect_driven;
   assign nv_wr = reg_wr && reg_addr == SURG_ADDR_WRCHK && reg_wdata[1:0] == SURG_WR_NV;
   // Warm-up count keeps the pipeline checks off values from before reset
   always_comb begin
      up_d   = (up_q == 3'h7) ? up_q : up_q + 3'h1;
      hold_d = (supply_reset_out && !cause) ? hold_q + 1 : 0;
   end
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         up_q   <= 3'h0;
         hold_q <= 0;
      end else begin
         up_q   <= up_d;
         hold_q <= hold_d;
      end
   end
   a_second_follow: assert property (up_q > 3'h4 |-> second_monitor_fail_out == $past(second_monitor_in, 3))
      else $error("second fail output does not track its comparator");
   a_third_follow: assert property (up_q > 3'h4 |-> third_monitor_fail_out == $past(third_monitor_in, 3))
      else $error("third fail output does not track its comparator");
   a_sda_sampled: assert property (up_q > 3'h4 |-> serial_data_sampled == $past(serial_data_in, 3))
      else $error("serial data sample is not live");
   a_cause_asserts: assert property (cause [*6] |-> supply_reset_out)
      else $error("reset output low while a cause is present");
   a_hold_min: assert property ($fell(cause) |-> ##4 supply_reset_out [*4])
      else $error("reset output released too early");
   a_hold_bound: assert property (hold_q <= HOLD_CYC_SEL3 + 8)
      else $error("reset output held beyond the longest hold time");
   a_nv_refused: assert property (wp_on [*4] ##0 nv_wr |=> write_refused && !write_allowed)
      else $error("nonvolatile write passed with protect high");
   a_nv_allowed: assert property ((!wp_on) [*4] ##0 nv_wr |=> write_allowed && !write_refused)
      else $error("nonvolatile write refused with protect off");
   a_ctrl_locked: assert property (wp_on [*4] ##0 (reg_wr && reg_addr == SURG_ADDR_CTRL) |=> write_refused)
      else $error("control register write passed with protect high");
   cover property ($fell(supply_reset_out));
   cover property (write_refused);
   cover property (write_allowed);
endmodule

bind surg_top surg_chk #(.HOLD_CYC_SEL3(HOLD_CYC_SEL3)) surg_chk_u (
   .sys_clk(sys_clk), .resetn(resetn), .supply_low_in(supply_low_in), .manual_reset_in(manual_reset_in),
   .write_protect_in(write_protect_in), .write_protect_driven(write_protect_driven),
   .second_monitor_in(second_monitor_in), .third_monitor_in(third_monitor_in), .serial_data_in(serial_data_in),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .supply_reset_out(supply_reset_out),
   .second_monitor_fail_out(second_monitor_fail_out), .third_monitor_fail_out(third_monitor_fail_out),
   .serial_data_sampled(serial_data_sampled), .write_allowed(write_allowed), .write_refused(write_refused));

// [tb/surg_top_tb.sv]
// Testbench: reset sequencing, monitor outputs and write guard of the supervisor
module surg_top_tb
   import surg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HOLD [4] = '{6, 8, 12, 16};
   logic       sys_clk = 1'b0;
   logic       resetn = 1'b0;
   logic       lo, man_rst, wpl, wpd, m2, m3, sda, wr, rd, wp_pin;
   logic [3:0] addr;
   logic [7:0] wdata, rdata;
   logic       rst_o, f2, f3, sda_s, w_ok, w_no;
   int         failures = 0;
   int         cmp_count = 0;
   surg_top #(.HOLD_CYC_SEL0(HOLD[0]), .HOLD_CYC_SEL1(HOLD[1]), .HOLD_CYC_SEL2(HOLD[2]), .HOLD_CYC_SEL3(HOLD[3])) dut_u (
      .sys_clk(sys_clk), .resetn(resetn), .supply_low_in(lo), .manual_reset_in(man_rst), .write_protect_in(wp_pin),
      .write_protect_driven(wpd), .second_monitor_in(m2), .third_monitor_in(m3), .serial_data_in(sda),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .supply_reset_out(rst_o),
      .second_monitor_fail_out(f2), .third_monitor_fail_out(f3), .serial_data_sampled(sda_s),
      .write_allowed(w_ok), .write_refused(w_no));
   surg_board board_u (.sys_clk(sys_clk), .wp_level(wpl), .wp_drive(wpd), .wp_pin(wp_pin));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic results();
      if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
      #1;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask
   // Called at the edge that drops the last cause; counts how long the output stays high
   task automatic hold_len(input int h);
      int n;
      n = 0;
      while (rst_o === 1'b1 && n < 100) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      chk(8'(n >= h && n <= h + 8), 8'h01);
   endtask
   task automatic t_power();
      cyc(5);
      #1;
      chk({7'h00, rst_o}, 8'h01);
      rreg(SURG_ADDR_CTRL, SURG_CTRL_RESET);
      @(posedge sys_clk);
      lo <= 1'b0;
      hold_len(HOLD[1]);
   endtask
   task automatic t_manual();
      for (int s = 0; s < 4; s++) begin
         wreg(SURG_ADDR_CTRL, 8'(s));
         @(posedge sys_clk);
         man_rst <= 1'b1;
         cyc(5);
         #1;
         chk({7'h00, rst_o}, 8'h01);
         @(posedge sys_clk);
         man_rst <= 1'b0;
         hold_len(HOLD[s]);
      end
   endtask
   // A second cause inside the hold window must start the count afresh
   task automatic t_restart();
      @(posedge sys_clk);
      man_rst <= 1'b1;
      cyc(3);
      man_rst <= 1'b0;
      cyc(8);
      lo <= 1'b1;
      cyc(3);
      lo <= 1'b0;
      hold_len(HOLD[3]);
   endtask
   task automatic t_mon();
      for (int v = 0; v < 3; v++) begin
         @(posedge sys_clk);
         m2 <= v[0];
         m3 <= ~v[0];
         sda <= v[0];
         cyc(3);
         #1;
         chk({5'h00, f2, f3, sda_s}, {5'h00, v[0], ~v[0], v[0]});
         rreg(SURG_ADDR_STATUS, {2'h0, v[0], 1'b0, ~v[0], v[0], 2'h0});
      end
   endtask
   task automatic t_guard();
      logic r;
      for (int b = 0; b < 2; b++) begin
         @(posedge sys_clk);
         wpd <= 1'b1;
         wpl <= 1'b0;
         cyc(4);
         wreg(SURG_ADDR_CTRL, b ? 8'h08 : 8'h00);
         for (int w = 0; w < 3; w++) begin
            for (int k = 1; k < 3; k++) begin
               @(posedge sys_clk);
               wpd <= (w != 1);
               wpl <= (w == 2);
               cyc(4);
               wreg(SURG_ADDR_WRCHK, 8'(k));
               r = (w == 2) && (k == 2 || b == 1);
               chk({6'h00, w_ok, w_no}, {6'h00, !r, r});
            end
         end
      end
      wreg(SURG_ADDR_CTRL, 8'h03);
      chk({7'h00, w_no}, 8'h01);
      rreg(SURG_ADDR_CTRL, 8'h08);
      rreg(4'hF, 8'h00);
      wreg(SURG_ADDR_WRCHK, 8'h00);
      chk({6'h00, w_ok, w_no}, 8'h00);
   endtask
   task automatic t_reset_mid();
      @(posedge sys_clk);
      resetn <= 1'b0;
      cyc(2);
      #1;
      chk({7'h00, rst_o}, 8'h01);
   endtask
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #200000;
      failures++;
      results();
   end
   initial begin
      {lo, man_rst, wpl, wpd, m2, m3, sda, wr, rd} = 9'h120;
      addr = 4'h0;
      wdata = 8'h00;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      t_power();
      t_manual();
      t_restart();
      t_mon();
      t_guard();
      t_reset_mid();
      results();
   end
endmodule
